// ===== common/nic_irq_consts.vh
// Summary of operation
// - Flags show which event raised the interrupt
// - Flag interrupts only when its mask bit set
// - Write one clears flag, zero leaves it
// - Hardware reset clears flags, software reset not
// - Bit 14 retry; latched mode only as master
// - Latched retry suspends DMA until flag cleared
// - Unlatched retry rerequests bus without waiting
// - Bit 13 set: no collision pulse in 6.4us
// - Bit 12 set when filter load completes
// - Bit 11 set on descriptor interrupt request during transmit config read
// - Bit 10 set after sequence word written
// - Bit 9 on end, halt or abort
// - Abort means any of four transmit error bits
// - Bit 9 only after status word written back
// - Bit 8 set for packet sent with error
// - Bits 3..1 set on tally counter wrap
// - Area exceeded: flag, abort packet, fetch next
`ifndef NIC_IRQ_CONSTS_VH
`define NIC_IRQ_CONSTS_VH

// Register select value of the event flag register
`define IEF_OFFSET          6'h05
`define IEF_RESET           15'h0000
`define IEF_TOP_ZERO        1'b0
`define FLAG_COUNT          15

// Flag positions
`define BIT_BUS_RETRY       14
`define BIT_HEARTBEAT_LOST  13
`define BIT_FILTER_DONE     12
`define BIT_PROGRAMMED_IRQ  11
`define BIT_PKT_RECEIVED    10
`define BIT_TX_DONE         9
`define BIT_TX_ERROR        8
`define BIT_TIMER_DONE      7
`define BIT_RX_DESC_EXH     6
`define BIT_RX_BUF_EXH      5
`define BIT_RX_AREA_EXC     4
`define BIT_CRC_ROLL        3
`define BIT_ALIGN_ROLL      2
`define BIT_MISSED_ROLL     1
`define BIT_RX_FIFO_OVR     0

// Heartbeat window timing
`define HB_WINDOW_NS        6400
`define CLK_PERIOD_NS       20
`define HB_WINDOW_CYCLES    (`HB_WINDOW_NS / `CLK_PERIOD_NS)
`define HB_COUNT_W          9
`define HB_COUNT_ZERO       9'h000

`endif

// ===== rtl/event_flag_cell.v
`timescale 1ns/100ps
`default_nettype none
`include "nic_irq_consts.vh"

module event_flag_cell (
   input  wire i_sys_clk,
   input  wire i_sys_rst,
   input  wire i_clk_en,
   input  wire i_set,
   input  wire i_clear,
   output reg  o_flag
);

   // Sticky flag; a set in the clearing cycle wins
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_flag <= 1'b0;
      end else if (i_clk_en) begin
         if (i_set) begin
            o_flag <= 1'b1;
         end else if (i_clear) begin
            o_flag <= 1'b0;
         end
      end
   end

endmodule // event_flag_cell
`default_nettype wire

// ===== rtl/heartbeat_window.v
`timescale 1ns/100ps
`default_nettype none
`include "nic_irq_consts.vh"

module heartbeat_window (
   input  wire i_sys_clk,
   input  wire i_sys_rst,
   input  wire i_clk_en,
   input  wire i_tx_finished,
   input  wire i_collision_pulse,
   output reg  o_heartbeat_lost
);

   // Last count of the window, cut to the counter width on purpose
   localparam integer           WINDOW_SPAN = `HB_WINDOW_CYCLES - 1;
   localparam [`HB_COUNT_W-1:0] WINDOW_LAST = WINDOW_SPAN[`HB_COUNT_W-1:0];

   reg [`HB_COUNT_W-1:0] count;
   reg                   watching;

   // Watch the first part of the gap for a collision pulse
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         count            <= `HB_COUNT_ZERO;
         watching         <= 1'b0;
         o_heartbeat_lost <= 1'b0;
      end else if (i_clk_en) begin
         o_heartbeat_lost <= 1'b0;
         if (i_tx_finished) begin
            count    <= `HB_COUNT_ZERO;
            watching <= 1'b1;
         end else if (watching) begin
            if (i_collision_pulse) begin
               watching <= 1'b0;
            end else if (count == WINDOW_LAST) begin
               watching         <= 1'b0;
               o_heartbeat_lost <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end

endmodule // heartbeat_window
`default_nettype wire

// ===== rtl/nic_interrupt_status.v
`timescale 1ns/100ps
`default_nettype none
`include "nic_irq_consts.vh"

module nic_interrupt_status (
   input  wire        i_sys_clk,
   input  wire        i_sys_rst,
   input  wire        i_clk_en,
   // Register access
   input  wire        i_chip_select,
   input  wire        i_read_strobe,
   input  wire        i_write_strobe,
   input  wire [5:0]  i_register_select_lines,
   input  wire [15:0] i_write_data,
   output reg  [15:0] o_read_data,
   output reg         o_read_valid,
   // Mask and configuration
   input  wire [15:0] i_interrupt_enable_bits,
   input  wire        i_latched_retry_select,
   // Bus retry
   input  wire        i_bus_retry_input,
   input  wire        i_bus_master,
   output wire        o_dma_suspend,
   output reg         o_bus_rerequest,
   // Heartbeat
   input  wire        i_tx_finished,
   input  wire        i_collision_pulse,
   // Filter load and descriptors
   input  wire        i_filter_load_complete,
   input  wire        i_tx_config_read,
   input  wire        i_descriptor_irq_request,
   input  wire        i_rx_sequence_written,
   // Transmit completion
   input  wire        i_tx_status_written,
   input  wire        i_end_of_list_marker,
   input  wire        i_halt_transmit_command,
   input  wire        i_byte_count_mismatch,
   input  wire        i_excessive_collisions,
   input  wire        i_fifo_underrun,
   input  wire        i_excessive_deferral,
   // Receive and timer events
   input  wire        i_timer_rollover,
   input  wire        i_rx_descriptors_exhausted,
   input  wire        i_rx_buffers_exhausted,
   input  wire        i_rx_area_exceeded,
   input  wire        i_rx_fifo_overrun,
   // Tally counters: bit 2 crc, bit 1 alignment, bit 0 missed
   input  wire [2:0]  i_tally_increment,
   input  wire [2:0]  i_tally_all_ones,
   // Results
   output reg         o_rx_packet_abort,
   output reg         o_fetch_next_resource,
   output wire [15:0] o_interrupt_event_flags,
   output wire        o_int
);

   wire [`FLAG_COUNT-1:0] flags;
   wire [`FLAG_COUNT-1:0] set_vec;
   wire [`FLAG_COUNT-1:0] clear_vec;
   wire                   heartbeat_lost;
   wire                   tx_abort;
   wire                   ief_write;
   wire                   ief_read;
   wire [2:0]             tally_wrap;

   // Register select decode
   function sel_hit;
      input [5:0] sel;
      begin
         sel_hit = (sel == `IEF_OFFSET);
      end
   endfunction

   assign ief_write = i_chip_select & i_write_strobe & sel_hit(i_register_select_lines);
   assign ief_read  = i_chip_select & i_read_strobe & sel_hit(i_register_select_lines);

   // Any transmit error bit counts as an abort
   assign tx_abort = i_byte_count_mismatch | i_excessive_collisions |
                     i_fifo_underrun | i_excessive_deferral;

   // Counter wraps when it steps past all ones
   assign tally_wrap = i_tally_increment & i_tally_all_ones;

   // Heartbeat window detector
   heartbeat_window u_heartbeat (
      .i_sys_clk         (i_sys_clk),
      .i_sys_rst         (i_sys_rst),
      .i_clk_en          (i_clk_en),
      .i_tx_finished     (i_tx_finished),
      .i_collision_pulse (i_collision_pulse),
      .o_heartbeat_lost  (heartbeat_lost)
   );

   // Event set terms
   assign set_vec[`BIT_BUS_RETRY]      = i_bus_retry_input &
                                         (~i_latched_retry_select | i_bus_master);
   assign set_vec[`BIT_HEARTBEAT_LOST] = heartbeat_lost;
   assign set_vec[`BIT_FILTER_DONE]    = i_filter_load_complete;
   assign set_vec[`BIT_PROGRAMMED_IRQ] = i_tx_config_read & i_descriptor_irq_request;
   assign set_vec[`BIT_PKT_RECEIVED]   = i_rx_sequence_written;
   assign set_vec[`BIT_TX_DONE]        = i_tx_status_written &
                                         (i_end_of_list_marker | i_halt_transmit_command |
                                          tx_abort);
   assign set_vec[`BIT_TX_ERROR]       = i_tx_status_written & tx_abort;
   assign set_vec[`BIT_TIMER_DONE]     = i_timer_rollover;
   assign set_vec[`BIT_RX_DESC_EXH]    = i_rx_descriptors_exhausted;
   assign set_vec[`BIT_RX_BUF_EXH]     = i_rx_buffers_exhausted;
   assign set_vec[`BIT_RX_AREA_EXC]    = i_rx_area_exceeded;
   assign set_vec[`BIT_CRC_ROLL]       = tally_wrap[2];
   assign set_vec[`BIT_ALIGN_ROLL]     = tally_wrap[1];
   assign set_vec[`BIT_MISSED_ROLL]    = tally_wrap[0];
   assign set_vec[`BIT_RX_FIFO_OVR]    = i_rx_fifo_overrun;

   // Write-one-to-clear terms
   assign clear_vec = {`FLAG_COUNT{ief_write}} & i_write_data[`FLAG_COUNT-1:0];

   // One sticky cell per flag
   genvar g;
   generate
      for (g = 0; g < `FLAG_COUNT; g = g + 1) begin : g_flag
         event_flag_cell u_cell (
            .i_sys_clk (i_sys_clk),
            .i_sys_rst (i_sys_rst),
            .i_clk_en  (i_clk_en),
            .i_set     (set_vec[g]),
            .i_clear   (clear_vec[g]),
            .o_flag    (flags[g])
         );
      end
   endgenerate

   // Top bit is always zero
   assign o_interrupt_event_flags = {`IEF_TOP_ZERO, flags};

   // Masked flags drive the pin
   assign o_int = |(flags & i_interrupt_enable_bits[`FLAG_COUNT-1:0]);

   // Latched retry holds DMA until the flag clears
   assign o_dma_suspend = i_latched_retry_select & flags[`BIT_BUS_RETRY];

   // Register read path
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_read_data  <= {`IEF_TOP_ZERO, `IEF_RESET};
         o_read_valid <= 1'b0;
      end else if (i_clk_en) begin
         o_read_valid <= ief_read;
         if (ief_read) begin
            o_read_data <= {`IEF_TOP_ZERO, flags};
         end
      end
   end

   // Retry and receive-area side effects
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_bus_rerequest       <= 1'b0;
         o_rx_packet_abort     <= 1'b0;
         o_fetch_next_resource <= 1'b0;
      end else if (i_clk_en) begin
         o_bus_rerequest       <= i_bus_retry_input & ~i_latched_retry_select;
         o_rx_packet_abort     <= i_rx_area_exceeded;
         o_fetch_next_resource <= i_rx_area_exceeded;
      end
   end

endmodule // nic_interrupt_status
`default_nettype wire

// ===== dv/irq_flags_sva.sv
`timescale 1ns/100ps
`default_nettype none
module irq_flags_sva (
   input wire logic        i_sys_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_clk_en,
   input wire logic        i_chip_select,
   input wire logic        i_read_strobe,
   input wire logic        i_write_strobe,
   input wire logic [5:0]  i_register_select_lines,
   input wire logic [15:0] i_write_data,
   input wire logic [15:0] o_read_data,
   input wire logic        o_read_valid,
   input wire logic [15:0] i_interrupt_enable_bits,
   input wire logic        i_latched_retry_select,
   input wire logic        i_bus_retry_input,
   input wire logic        i_bus_master,
   input wire logic        o_dma_suspend,
   input wire logic [15:0] o_interrupt_event_flags,
   input wire logic        o_int
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // Decoded accesses and retry events
   wire logic [15:0] f = o_interrupt_event_flags;
   wire logic hit = i_clk_en && i_chip_select && i_register_select_lines == 6'h05;
   wire logic rd_hit = hit && i_read_strobe;
   wire logic wr_hit = hit && i_write_strobe;
   wire logic [15:0] clr = wr_hit ? i_write_data : 16'h0000;
   wire logic retry = i_clk_en && i_bus_retry_input;
   // Read answer one cycle after the take edge
   sequence s_answer;
      o_read_valid && o_read_data == {1'b0, $past(f[14:0])};
   endsequence
   a_read_data: assert property (rd_hit |=> s_answer) else $error("bad read answer");
   a_int_gate: assert property (o_int == |(f[14:0] & i_interrupt_enable_bits[14:0]))
      else $error("bad int");
   a_top_zero: assert property (f[15] == 1'b0) else $error("bit 15 set");
   a_flag_hold: assert property (!i_sys_rst |=> ($past(f) & ~$past(clr) & ~f) == 16'h0000)
      else $error("flag lost");
   a_w1c_retry: assert property (wr_hit && i_write_data[14] && !retry |=> !f[14]) else $error("no clear");
   a_retry_set: assert property (retry && (i_bus_master || !i_latched_retry_select) |=> f[14])
      else $error("no retry flag");
   a_retry_refuse: assert property (retry && i_latched_retry_select && !i_bus_master && !f[14] |=> !f[14])
      else $error("retry flagged");
   a_dma_hold: assert property (o_dma_suspend == (i_latched_retry_select && f[14])) else $error("bad suspend");
endmodule // irq_flags_sva
bind nic_interrupt_status irq_flags_sva u_sva (.i_sys_clk, .i_sys_rst, .i_clk_en, .i_chip_select, .i_read_strobe,
   .i_write_strobe, .i_register_select_lines, .i_write_data, .o_read_data, .o_read_valid, .i_interrupt_enable_bits,
   .i_latched_retry_select, .i_bus_retry_input, .i_bus_master, .o_dma_suspend, .o_interrupt_event_flags, .o_int);
`default_nettype wire

// ===== dv/host_access_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_access_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_read_valid,
   input  wire logic [15:0] i_read_data,
   output var  logic        o_cs,
   output var  logic        o_rd,
   output var  logic        o_wr,
   output var  logic [5:0]  o_sel,
   output var  logic [15:0] o_wdata
);
   // Idle bus at time zero
   initial begin
      o_cs = 1'b0;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_sel = 6'h00;
      o_wdata = 16'h0000;
   end
   // One access, held through the take edge, then released
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d, output logic v, output logic [15:0] q);
      @(posedge i_sys_clk);
      o_cs <= 1'b1;
      o_rd <= ~w;
      o_wr <= w;
      o_sel <= a;
      o_wdata <= d;
      @(posedge i_sys_clk);
      o_cs <= 1'b0;
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_sel <= ~a;
      o_wdata <= ~d;
      #1;
      v = i_read_valid;
      q = i_read_data;
   endtask
endmodule // host_access_model
`default_nettype wire

// ===== dv/nic_interrupt_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
module nic_interrupt_status_tb;
   logic        clk, rst, cs, rd, wr, v, rv, dsup, irq, rrq, pab, fnr;
   logic [27:0] ev, s;
   logic [15:0] mask, wd, rdat, q, fl;
   logic [5:0]  sel;
   int          err_total, samples_checked;
   nic_interrupt_status uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(ev[27]), .i_chip_select(cs),
      .i_read_strobe(rd), .i_write_strobe(wr), .i_register_select_lines(sel), .i_write_data(wd),
      .o_read_data(rdat), .o_read_valid(rv), .i_interrupt_enable_bits(mask), .i_latched_retry_select(ev[26]),
      .i_bus_retry_input(ev[14]), .i_bus_master(ev[8]), .o_dma_suspend(dsup), .o_bus_rerequest(rrq),
      .i_tx_finished(ev[13]), .i_collision_pulse(ev[15]), .i_filter_load_complete(ev[12]),
      .i_tx_config_read(ev[11]), .i_descriptor_irq_request(ev[16]), .i_rx_sequence_written(ev[10]),
      .i_tx_status_written(ev[9]), .i_end_of_list_marker(ev[17]), .i_halt_transmit_command(ev[18]),
      .i_byte_count_mismatch(ev[19]), .i_excessive_collisions(ev[20]), .i_fifo_underrun(ev[21]),
      .i_excessive_deferral(ev[22]), .i_timer_rollover(ev[7]), .i_rx_descriptors_exhausted(ev[6]),
      .i_rx_buffers_exhausted(ev[5]), .i_rx_area_exceeded(ev[4]), .i_rx_fifo_overrun(ev[0]),
      .i_tally_increment(ev[3:1]), .i_tally_all_ones(ev[25:23]), .o_rx_packet_abort(pab),
      .o_fetch_next_resource(fnr), .o_interrupt_event_flags(fl), .o_int(irq));
   host_access_model u_host (.i_sys_clk(clk), .i_read_valid(rv), .i_read_data(rdat), .o_cs(cs), .o_rd(rd),
      .o_wr(wr), .o_sel(sel), .o_wdata(wd));
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [15:0] exp);
      u_host.xfer(1'b0, 6'h05, 16'h0000, v, q);
      chk({15'h0000, v}, 16'h0001);
      chk(q, exp);
   endtask
   task automatic wr_reg(input logic [15:0] d);
      u_host.xfer(1'b1, 6'h05, d, v, q);
   endtask
   // One-cycle event pulse, settled on return
   task automatic fire(input logic [27:0] p);
      @(posedge clk);
      ev <= ev | p;
      @(posedge clk);
      ev <= ev & ~p;
      #1;
   endtask
   task automatic wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      wrap_up;
   end
   initial begin
      err_total = 0;
      samples_checked = 0;
      rst = 1'b1;
      ev = 28'h800_0100;
      mask = 16'h0000;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_chk(16'h0000);
      // Each flag alone except bits 8 and 13: set, mask gating, write zero, write one
      for (int k = 0; k < 15; k++) begin
         if (k == 8 || k == 13)
            continue;
         s = 28'h000_0000;
         s[k] = 1'b1;
         if (k > 0 && k < 4)
            s[22 + k] = 1'b1;
         s[16] = (k == 11);
         s[17] = (k == 9);
         fire(s);
         chk(fl, 16'h0001 << k);
         chk({13'h0000, pab, fnr, rrq}, {13'h0000, k == 4, k == 4, k == 14});
         rd_chk(16'h0001 << k);
         chk({15'h0000, irq}, 16'h0000);
         @(posedge clk);
         mask <= 16'h0001 << k;
         wr_reg(16'h0000);
         rd_chk(16'h0001 << k);
         chk({15'h0000, irq}, 16'h0001);
         wr_reg(16'h0001 << k);
         rd_chk(16'h0000);
         chk({15'h0000, irq}, 16'h0000);
      end
      $display("test single flags done");
      for (int j = 17; j < 23; j++) begin
         s = 28'h000_0200;
         s[j] = 1'b1;
         fire(s);
         rd_chk(j > 18 ? 16'h0300 : 16'h0200);
         wr_reg(16'h0300);
      end
      fire(28'h000_0200);
      fire(28'h000_0800);
      fire(28'h000_0002);
      rd_chk(16'h0000);
      $display("test transmit done");
      @(posedge clk);
      ev[26] <= 1'b1;
      ev[8] <= 1'b0;
      fire(28'h000_4000);
      chk({15'h0000, rrq}, 16'h0000);
      rd_chk(16'h0000);
      @(posedge clk);
      ev[8] <= 1'b1;
      fire(28'h000_4000);
      rd_chk(16'h4000);
      chk({15'h0000, dsup}, 16'h0001);
      wr_reg(16'h4000);
      chk({15'h0000, dsup}, 16'h0000);
      @(posedge clk);
      ev[26] <= 1'b0;
      fire(28'h000_4000);
      chk({15'h0000, dsup}, 16'h0000);
      chk({15'h0000, rrq}, 16'h0001);
      wr_reg(16'h4000);
      $display("test bus retry done");
      fire(28'h000_2000);
      repeat (300) @(posedge clk);
      rd_chk(16'h0000);
      repeat (30) @(posedge clk);
      rd_chk(16'h2000);
      wr_reg(16'h2000);
      fire(28'h000_2000);
      repeat (100) @(posedge clk);
      fire(28'h000_8000);
      repeat (330) @(posedge clk);
      rd_chk(16'h0000);
      $display("test heartbeat done");
      u_host.xfer(1'b0, 6'h04, 16'h0000, v, q);
      chk({15'h0000, v}, 16'h0000);
      // Clock enable low: no flag set, no read answer
      @(posedge clk);
      ev[27] <= 1'b0;
      fire(28'h000_0001);
      chk(fl, 16'h0000);
      u_host.xfer(1'b0, 6'h05, 16'h0000, v, q);
      chk({15'h0000, v}, 16'h0000);
      @(posedge clk);
      ev[27] <= 1'b1;
      fire(28'h000_0001);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd_chk(16'h0000);
      $display("test unmapped and reset done");
      wrap_up;
   end
endmodule // nic_interrupt_status_tb
`default_nettype wire
